// ==== logic/pcf_core.sv ====
// pcf_core: per-lane transmit and receive core queues with status flags
// assumes fabric and PCS sides share clk; only latency_sclk is synchronised here
// Functional notes
// - transmit full flag asserts whenever the transmit queue is full
// - transmit almost-full asserts at the static partially-full level
// - transmit empty is a stretched pulse lasting 2 to 3 cycles
// - optional transmit almost-empty is a 2 to 3 cycle pulse
// - receive word-valid marks valid words; fabric drops the others
// - receive full is a stretched pulse lasting 2 to 3 cycles
// - receive almost-full is a 2 to 3 cycle pulse at threshold
// - receive empty asserts whenever the receive queue holds nothing
// - receive almost-empty asserts at the partially-empty level
// - in 10G mode a deleted word pulses the drop flag 2 to 3 cycles
// - in 10G mode an inserted word raises the added flag
// - Interlaken or Basic: one pop per cycle with read strobe high
// - Interlaken realign request clears the receive queue and alignment
// - latency pulses for both queues of each direction from reference clock
// - write-side and read-side signals are synchronous to their clocks
// - fabric clock drives transmit write and receive read sides
`default_nettype none
module pcf_core
    import pcf_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire pcf_pkg::pcf_mode_t      mode,
    input  wire logic                    pempty_en,
    input  wire logic                    latency_sclk,
    input  wire logic [LANES-1:0]        tx_wr_en,
    input  wire logic [LANES-1:0]        tx_gb_valid,
    input  wire logic [LANES*WORD_W-1:0] tx_data,
    input  wire logic [LANES-1:0]        pcs_tx_rd,
    output var  logic [LANES*WORD_W-1:0] pcs_tx_data,
    output var  logic [LANES-1:0]        tx_full,
    output var  logic [LANES-1:0]        tx_pfull,
    output var  logic [LANES-1:0]        tx_empty,
    output var  logic [LANES-1:0]        tx_pempty,
    input  wire logic [LANES-1:0]        pcs_rx_wr,
    input  wire logic [LANES-1:0]        pcs_rx_ins,
    input  wire logic [LANES-1:0]        pcs_rx_del,
    input  wire logic [LANES*WORD_W-1:0] pcs_rx_data,
    input  wire logic [LANES-1:0]        rx_rd_en,
    input  wire logic [LANES-1:0]        rx_align_clr,
    output var  logic [LANES*WORD_W-1:0] rx_data,
    output var  logic [LANES-1:0]        rx_valid,
    output var  logic [LANES-1:0]        rx_gb_valid,
    output var  logic [LANES-1:0]        rx_full,
    output var  logic [LANES-1:0]        rx_pfull,
    output var  logic [LANES-1:0]        rx_empty,
    output var  logic [LANES-1:0]        rx_pempty,
    output var  logic [LANES-1:0]        rx_del,
    output var  logic [LANES-1:0]        rx_ins,
    output var  logic [LANES-1:0]        align_search,
    output var  logic                    tx_core_lat_pulse,
    output var  logic                    tx_pcs_lat_pulse,
    output var  logic                    rx_core_lat_pulse,
    output var  logic                    rx_pcs_lat_pulse
);
    function automatic logic fifo_mode_strobe(input pcf_mode_t m);
        fifo_mode_strobe = (m == PCF_MODE_BASIC) || (m == PCF_MODE_ILK);
    endfunction : fifo_mode_strobe

    // latency reference synchroniser and divided edge
    typedef struct packed
    {
        logic [1:0] sync;
        logic       prev;
        logic [3:0] div;
        logic [3:0] pulse;
    } pcf_lat_t;
    pcf_lat_t l_q;
    pcf_lat_t l_d;
    always_comb
    begin
        l_d       = l_q;
        l_d.sync  = {l_q.sync[0], latency_sclk};
        l_d.prev  = l_q.sync[1];
        l_d.pulse = 4'h0;
        if (l_q.sync[1] && !l_q.prev)
        begin
            l_d.div = l_q.div + 4'h1;
            if (l_q.div == LAT_DIV)
            begin
                l_d.pulse = 4'hF;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            l_q <= '0;
        end
        else
        begin
            l_q <= l_d;
        end
    end
    assign tx_core_lat_pulse = l_q.pulse[0];
    assign tx_pcs_lat_pulse  = l_q.pulse[1];
    assign rx_core_lat_pulse = l_q.pulse[2];
    assign rx_pcs_lat_pulse  = l_q.pulse[3];

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            typedef struct packed
            {
                logic [PTR_W-1:0]  twp;
                logic [PTR_W-1:0]  trp;
                logic [CNT_W-1:0]  tcnt;
                logic [PTR_W-1:0]  rwp;
                logic [PTR_W-1:0]  rrp;
                logic [CNT_W-1:0]  rcnt;
                logic [2:0]        aln;
                logic              srch;
                logic [WORD_W-1:0] tout;
                logic [WORD_W-1:0] rout;
                logic              rvld;
                logic              rgbv;
                logic              tfull;
                logic              tpfull;
                logic              rempty;
                logic              rpempty;
                logic              rins;
                logic              ev_te;
                logic              ev_tpe;
                logic              ev_rf;
                logic              ev_rpf;
                logic              ev_del;
                logic              was_te;
                logic              was_tpe;
                logic              was_rf;
                logic              was_rpf;
            } pcf_lane_t;
            pcf_lane_t s_q;
            pcf_lane_t s_d;
            logic [WORD_W-1:0] tmem [DEPTH];
            logic [WORD_W-1:0] rmem [DEPTH];
            logic push_t;
            logic pop_t;
            logic push_r;
            logic pop_r;
            logic [CNT_W-1:0] tn;
            logic [CNT_W-1:0] rn;
            always_comb
            begin
                s_d    = s_q;
                // write strobe or gearbox valid qualifies data by mode
                push_t = (fifo_mode_strobe(mode) ? tx_wr_en[g] : tx_gb_valid[g]) && s_q.tcnt != FULL_LVL;
                pop_t  = pcs_tx_rd[g] && s_q.tcnt != EMPTY_LVL;
                push_r = (pcs_rx_wr[g] || pcs_rx_ins[g]) && s_q.rcnt != FULL_LVL && !s_q.srch;
                pop_r  = (fifo_mode_strobe(mode) ? rx_rd_en[g] : 1'b1) && s_q.rcnt != EMPTY_LVL;
                tn     = CNT_W'(s_q.tcnt + CNT_W'(push_t) - CNT_W'(pop_t));
                rn     = CNT_W'(s_q.rcnt + CNT_W'(push_r) - CNT_W'(pop_r));
                if (push_t)
                begin
                    s_d.twp = s_q.twp + PTR_W'(1);
                end
                if (pop_t)
                begin
                    s_d.trp  = s_q.trp + PTR_W'(1);
                    s_d.tout = tmem[s_q.trp];
                end
                if (push_r)
                begin
                    s_d.rwp = s_q.rwp + PTR_W'(1);
                end
                s_d.rvld = pop_r;
                s_d.rgbv = pop_r && !fifo_mode_strobe(mode);
                if (pop_r)
                begin
                    s_d.rrp  = s_q.rrp + PTR_W'(1);
                    s_d.rout = rmem[s_q.rrp];
                end
                // realign: flush receive queue, hold search while requested
                if (mode == PCF_MODE_ILK && rx_align_clr[g])
                begin
                    s_d.aln = (s_q.aln == ALIGN_CY) ? s_q.aln : s_q.aln + 3'h1;
                    s_d.rwp  = '0;
                    s_d.rrp  = '0;
                    s_d.srch = 1'b1;
                    s_d.rvld = 1'b0;
                    s_d.rgbv = 1'b0;
                    rn       = EMPTY_LVL;
                end
                else
                begin
                    s_d.aln = 3'h0;
                    // first word after a realign is the marker: it ends the search unstored
                    if (pcs_rx_wr[g] || pcs_rx_ins[g])
                    begin
                        s_d.srch = 1'b0;
                    end
                end
                s_d.ev_del  = mode == PCF_MODE_10GR && pcs_rx_del[g] && s_q.rcnt != EMPTY_LVL;
                if (s_d.ev_del)
                begin
                    // deleted word never reaches the read side
                    s_d.rvld = 1'b0;
                    s_d.rgbv = 1'b0;
                    if (!pop_r)
                    begin
                        s_d.rrp = s_q.rrp + PTR_W'(1);
                        rn      = CNT_W'(rn - ONE_LVL);
                    end
                end
                s_d.tcnt    = tn;
                s_d.rcnt    = rn;
                s_d.tfull   = tn == FULL_LVL;
                s_d.tpfull  = tn >= PFULL_LVL;
                s_d.rempty  = rn == EMPTY_LVL;
                s_d.rpempty = rn <= PEMPTY_LVL;
                s_d.rins    = mode == PCF_MODE_10GR && pcs_rx_ins[g] && push_r;
                // status pulses fire on entry only; a fresh reset counts as entering empty
                s_d.was_te  = tn == EMPTY_LVL;
                s_d.was_tpe = pempty_en && tn <= PEMPTY_LVL;
                s_d.was_rf  = rn == FULL_LVL;
                s_d.was_rpf = rn >= PFULL_LVL;
                s_d.ev_te   = s_d.was_te && !s_q.was_te;
                s_d.ev_tpe  = s_d.was_tpe && !s_q.was_tpe;
                s_d.ev_rf   = s_d.was_rf && !s_q.was_rf;
                s_d.ev_rpf  = s_d.was_rpf && !s_q.was_rpf;
            end
            always_ff @(posedge clk)
            begin
                if (push_t)
                begin
                    tmem[s_q.twp] <= tx_data[g*WORD_W +: WORD_W];
                end
                if (push_r)
                begin
                    rmem[s_q.rwp] <= pcs_rx_data[g*WORD_W +: WORD_W];
                end
            end
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    s_q         <= '0;
                    s_q.rempty  <= 1'b1;
                    s_q.rpempty <= 1'b1;
                end
                else
                begin
                    s_q <= s_d;
                end
            end
            pcf_stretch u_te  (.clk(clk), .rst_b(rst_b), .event_in(s_q.ev_te),  .level_out(tx_empty[g]));
            pcf_stretch u_tpe (.clk(clk), .rst_b(rst_b), .event_in(s_q.ev_tpe), .level_out(tx_pempty[g]));
            pcf_stretch u_rf  (.clk(clk), .rst_b(rst_b), .event_in(s_q.ev_rf),  .level_out(rx_full[g]));
            pcf_stretch u_rpf (.clk(clk), .rst_b(rst_b), .event_in(s_q.ev_rpf), .level_out(rx_pfull[g]));
            pcf_stretch u_del (.clk(clk), .rst_b(rst_b), .event_in(s_q.ev_del), .level_out(rx_del[g]));
            assign pcs_tx_data[g*WORD_W +: WORD_W] = s_q.tout;
            assign rx_data[g*WORD_W +: WORD_W]     = s_q.rout;
            assign rx_valid[g]     = s_q.rvld;
            assign rx_gb_valid[g]  = s_q.rgbv;
            assign tx_full[g]      = s_q.tfull;
            assign tx_pfull[g]     = s_q.tpfull;
            assign rx_empty[g]     = s_q.rempty;
            assign rx_pempty[g]    = s_q.rpempty;
            assign rx_ins[g]       = s_q.rins;
            assign align_search[g] = s_q.srch;
        end
    endgenerate
endmodule : pcf_core
`default_nettype wire

// ==== logic/pcf_pkg.sv ====
// pcf_pkg: constants and types for the per-lane core-side queue interface
// assumes a single 125 MHz clock domain for fabric and PCS sides
`default_nettype none
package pcf_pkg;
    localparam int unsigned LANES      = 2;
    localparam int unsigned WORD_W     = 64;
    localparam int unsigned DEPTH      = 16;
    localparam int unsigned PTR_W      = 4;
    localparam int unsigned CNT_W      = 5;
    localparam logic [4:0]  PFULL_LVL  = 5'h0C;
    localparam logic [4:0]  PEMPTY_LVL = 5'h02;
    localparam logic [4:0]  FULL_LVL   = 5'h10;
    localparam logic [4:0]  EMPTY_LVL  = 5'h00;
    localparam logic [4:0]  ONE_LVL    = 5'h01;
    // async status pulses stand 2 to 3 cycles; we hold 3
    localparam int unsigned STRETCH_NS = 24;
    localparam int unsigned CLK_NS     = 8;
    localparam logic [1:0]  STRETCH_CY = 2'(STRETCH_NS / CLK_NS);
    localparam int unsigned ALIGN_MIN  = 4;
    localparam logic [2:0]  ALIGN_CY   = 3'(ALIGN_MIN);
    localparam logic [3:0]  LAT_DIV    = 4'hF;
    typedef enum logic [1:0]
    {
        PCF_MODE_BASIC = 2'b00,
        PCF_MODE_ILK   = 2'b01,
        PCF_MODE_10GR  = 2'b10,
        PCF_MODE_PHASE = 2'b11
    } pcf_mode_t;
endpackage : pcf_pkg
`default_nettype wire

// ==== logic/pcf_stretch.sv ====
// pcf_stretch: holds a one-cycle event high for a fixed number of cycles
// assumes the event comes from logic on the same clock
`default_nettype none
module pcf_stretch
    import pcf_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic event_in,
    output var  logic level_out
);
    typedef struct packed
    {
        logic [1:0] cnt;
        logic       out;
    } pcf_str_st_t;
    pcf_str_st_t s_q;
    pcf_str_st_t s_d;
    always_comb
    begin
        s_d = s_q;
        if (event_in)
        begin
            s_d.cnt = STRETCH_CY - 2'h1;
            s_d.out = 1'b1;
        end
        else if (s_q.cnt != 2'h0)
        begin
            s_d.cnt = s_q.cnt - 2'h1;
        end
        else
        begin
            s_d.out = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    assign level_out = s_q.out;
endmodule : pcf_stretch
`default_nettype wire

// ==== bench/pcf_core_properties.sv ====
// pcf_core_properties: port timing checks of pcf_core, lane 0
// assumes one clock domain and async active-low reset
`default_nettype none
module pcf_core_properties
    import pcf_pkg::*;
(
    input wire logic               clk,
    input wire logic               rst_b,
    input wire pcf_pkg::pcf_mode_t mode,
    input wire logic [LANES-1:0]   tx_wr_en,
    input wire logic [LANES-1:0]   tx_gb_valid,
    input wire logic [LANES-1:0]   tx_full,
    input wire logic [LANES-1:0]   tx_pfull,
    input wire logic [LANES-1:0]   rx_full,
    input wire logic [LANES-1:0]   rx_del,
    input wire logic [LANES-1:0]   pcs_rx_del,
    input wire logic [LANES-1:0]   rx_ins,
    input wire logic [LANES-1:0]   pcs_rx_ins,
    input wire logic [LANES-1:0]   pcs_rx_wr,
    input wire logic [LANES-1:0]   rx_rd_en,
    input wire logic [LANES-1:0]   rx_empty,
    input wire logic [LANES-1:0]   rx_align_clr,
    input wire logic [LANES-1:0]   rx_valid,
    input wire logic [LANES-1:0]   align_search
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_full_cause: assert property ($rose(tx_full[0]) |-> $past(tx_wr_en[0] | tx_gb_valid[0]))
        else $error("full flag rose without a push");
    a_full_pfull: assert property (tx_full[0] |-> tx_pfull[0])
        else $error("full without almost-full");
    a_rxfull_hold: assert property ($rose(rx_full[0]) |-> rx_full[0] [*2])
        else $error("receive full pulse shorter than two cycles");
    a_drop_cause: assert property ($rose(rx_del[0]) |-> $past(pcs_rx_del[0]) || $past(pcs_rx_del[0], 2))
        else $error("drop flag without a delete");
    a_ins_cause: assert property ($rose(rx_ins[0]) |-> $past(pcs_rx_ins[0]))
        else $error("added flag without an insert");
    a_pop_valid: assert property (mode == PCF_MODE_BASIC && rx_rd_en[0] && !rx_empty[0]
        && !rx_align_clr[0] |=> rx_valid[0])
        else $error("pop gave no valid word");
    a_valid_cause: assert property (rx_valid[0] && mode == PCF_MODE_BASIC
        |-> $past(rx_rd_en[0] && !rx_empty[0]))
        else $error("valid word without a pop");
    a_empty_stays: assert property (rx_empty[0] && !pcs_rx_wr[0] && !pcs_rx_ins[0] |=> rx_empty[0])
        else $error("empty flag fell without a push");
    a_realign_clear: assert property (rx_align_clr[0] && mode == PCF_MODE_ILK
        |=> rx_empty[0] && align_search[0])
        else $error("realign did not clear the queue");
    a_search_ends: assert property (align_search[0] && !rx_align_clr[0] && pcs_rx_wr[0]
        |=> !align_search[0])
        else $error("alignment search did not end on a word");
endmodule : pcf_core_properties
bind pcf_core pcf_core_properties u_props (.clk, .rst_b, .mode, .tx_wr_en, .tx_gb_valid, .tx_full, .tx_pfull,
    .rx_full, .rx_del, .pcs_rx_del, .rx_ins, .pcs_rx_ins, .pcs_rx_wr, .rx_rd_en, .rx_empty, .rx_align_clr,
    .rx_valid, .align_search);
`default_nettype wire

// ==== bench/pcf_fabric_model.sv ====
// pcf_fabric_model: fabric logic that writes and reads lane data
// assumes flags come registered from pcf_core on the same clock
`default_nettype none
module pcf_fabric_model
    import pcf_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire pcf_pkg::pcf_mode_t mode,
    input  wire logic [LANES-1:0]   want_push,
    input  wire logic [LANES-1:0]   want_pop,
    input  wire logic [LANES-1:0]   tx_full,
    input  wire logic [LANES-1:0]   rx_empty,
    input  wire logic [LANES-1:0]   rx_valid,
    input  wire logic [LANES-1:0]   rx_gb_valid,
    input  wire logic [WORD_W-1:0]  rx_word,
    output logic [LANES-1:0]        tx_wr_en,
    output logic [LANES-1:0]        tx_gb_valid,
    output logic [LANES-1:0]        rx_rd_en,
    output logic [WORD_W-1:0]       got_word,
    output logic [7:0]              got_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic             fifo_mode;
    logic [LANES-1:0] push_ok;
    logic             take;
    assign fifo_mode = (mode == PCF_MODE_BASIC) || (mode == PCF_MODE_ILK);
    assign push_ok = (mode == PCF_MODE_PHASE) ? want_push : want_push & ~tx_full;
    assign tx_wr_en = fifo_mode ? push_ok : '0;
    assign tx_gb_valid = fifo_mode ? '0 : push_ok;
    assign rx_rd_en = want_pop & ~rx_empty;
    assign take = fifo_mode ? rx_valid[0] : rx_gb_valid[0];
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            got_word <= '0;
            got_cnt  <= 8'h00;
        end
        else if (take)
        begin
            got_word <= rx_word;
            got_cnt  <= got_cnt + 8'h01;
        end
    end
endmodule : pcf_fabric_model
`default_nettype wire

// ==== bench/pcs_core_fifo_interface_bench.sv ====
// pcs_core_fifo_interface_bench: self-checking bench for pcf_core
// assumes pcf_fabric_model as fabric side and a bound property checker
`default_nettype none
module pcs_core_fifo_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pcf_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, pempty_en = 1'b1, latency_sclk = 1'b0, clr_seen = 1'b0;
    pcf_mode_t mode = PCF_MODE_BASIC;
    logic [LANES-1:0] want_push = '0, want_pop = '0, pcs_tx_rd = '0, pcs_rx_wr = '0;
    logic [LANES-1:0] pcs_rx_ins = '0, pcs_rx_del = '0, rx_align_clr = '0;
    logic [LANES*WORD_W-1:0] tx_data = '0, pcs_rx_data = '0, pcs_tx_data, rx_data;
    logic [LANES-1:0] tx_wr_en, tx_gb_valid, tx_full, tx_pfull, tx_empty, tx_pempty, rx_rd_en, rx_valid;
    logic [LANES-1:0] rx_gb_valid, rx_full, rx_pfull, rx_empty, rx_pempty, rx_del, rx_ins, align_search;
    logic tx_core_lat_pulse, tx_pcs_lat_pulse, rx_core_lat_pulse, rx_pcs_lat_pulse;
    logic [WORD_W-1:0] got_word;
    logic [7:0] got_cnt, seen = 8'h00, lat_div = 8'h00;
    int miscompares = 0, checks = 0;
    pcf_core uut (.clk, .rst_b, .mode, .pempty_en, .latency_sclk, .tx_wr_en, .tx_gb_valid, .tx_data,
        .pcs_tx_rd, .pcs_tx_data, .tx_full, .tx_pfull, .tx_empty, .tx_pempty, .pcs_rx_wr, .pcs_rx_ins,
        .pcs_rx_del, .pcs_rx_data, .rx_rd_en, .rx_align_clr, .rx_data, .rx_valid, .rx_gb_valid, .rx_full,
        .rx_pfull, .rx_empty, .rx_pempty, .rx_del, .rx_ins, .align_search, .tx_core_lat_pulse,
        .tx_pcs_lat_pulse, .rx_core_lat_pulse, .rx_pcs_lat_pulse);
    pcf_fabric_model model (.clk, .rst_b, .mode, .want_push, .want_pop, .tx_full, .rx_empty, .rx_valid,
        .rx_gb_valid, .rx_word(rx_data[WORD_W-1:0]), .tx_wr_en, .tx_gb_valid, .rx_rd_en, .got_word, .got_cnt);
    always #4 clk = ~clk;
    // slow reference clock, eight cycles a period
    always @(posedge clk) lat_div <= lat_div + 8'h01;
    always @(posedge clk) latency_sclk <= lat_div[2];
    // sticky record of short pulses
    always @(posedge clk) seen <= clr_seen ? 8'h00 : seen | {tx_pcs_lat_pulse & rx_pcs_lat_pulse,
        tx_core_lat_pulse & rx_core_lat_pulse, rx_del[0], rx_ins[0], rx_pfull[0], rx_full[0], tx_pempty[0], tx_empty[0]};
    task complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
            miscompares++;
        end
    endtask : check
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task clear;
        @(posedge clk) clr_seen <= 1'b1;
        @(posedge clk) clr_seen <= 1'b0;
    endtask : clear
    task restart(input pcf_mode_t m);
        @(posedge clk) rst_b <= 1'b0;
        mode <= m;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
    endtask : restart
    task xmit(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk) want_push[0] <= 1'b1;
            tx_data[63:0] <= 64'(i);
        end
        @(posedge clk) want_push[0] <= 1'b0;
    endtask : xmit
    task drain(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk) pcs_tx_rd[0] <= 1'b1;
            @(posedge clk) pcs_tx_rd[0] <= 1'b0;
            #1 check(pcs_tx_data[63:0], 64'(i));
        end
    endtask : drain
    task feed(input int n, input logic ins, input logic del);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk) pcs_rx_wr[0] <= 1'b1;
            pcs_rx_ins[0] <= ins;
            pcs_rx_del[0] <= del && (i == n - 1);
            pcs_rx_data[63:0] <= 64'h100 + 64'(i);
        end
        @(posedge clk) {pcs_rx_wr[0], pcs_rx_ins[0], pcs_rx_del[0]} <= 3'h0;
    endtask : feed
    initial
    begin
        #50000;
        miscompares++;
        complete_run;
    end
    initial
    begin
        restart(PCF_MODE_BASIC);
        step(4);
        check(rx_empty[0], 1);
        check(rx_pempty[0], 1);
        check(seen[0], 1);
        step(2);
        check(tx_empty[0], 0);
        clear;
        xmit(16);
        step(2);
        check(tx_full[0], 1);
        check(tx_pfull[0], 1);
        check(tx_full[1], 0);
        drain(16);
        step(4);
        check(tx_full[0], 0);
        check(seen[1:0], 2'h3);
        clear;
        feed(16, 1'b0, 1'b0);
        step(4);
        check(seen[3:2], 2'h3);
        check(rx_full[0], 0);
        @(posedge clk) want_pop[0] <= 1'b1;
        repeat (18) @(posedge clk);
        want_pop[0] <= 1'b0;
        step(3);
        check(got_cnt, 16);
        check(got_word, 64'h10F);
        check(rx_empty[0], 1);
        restart(PCF_MODE_ILK);
        feed(3, 1'b0, 1'b0);
        step(2);
        check(rx_pempty[0], 0);
        @(posedge clk) rx_align_clr[0] <= 1'b1;
        repeat (4) @(posedge clk);
        rx_align_clr[0] <= 1'b0;
        step(2);
        check({rx_empty[0], align_search[0]}, 2'h3);
        feed(2, 1'b0, 1'b0);
        step(2);
        check(align_search[0], 0);
        restart(PCF_MODE_10GR);
        clear;
        feed(1, 1'b1, 1'b0);
        feed(3, 1'b0, 1'b1);
        step(6);
        check(seen[5:4], 2'h3);
        check(got_cnt, 8'h03);
        check(got_word, 64'h102);
        restart(PCF_MODE_PHASE);
        xmit(2);
        drain(2);
        clear;
        step(300);
        check(seen[7:6], 2'h3);
        complete_run;
    end
endmodule : pcs_core_fifo_interface_bench
`default_nettype wire
